//--- hw/nv_access.sv
// Purpose: control register and sequencing for a byte-wide nonvolatile store
// Assumes: apb slave, 200 MHz clk, synchronous active-high reset
// Notes: the storage array is inside; write time is a parameter
//
// Our own choice: register access over APB.
`include "nv_access_defs.svh"
`default_nettype none
// Behaviour
// - control bits 7..4 always read zero
// - ready interrupt needs global flag and enable
// - ready interrupt level while write strobe zero
// - write strobe ignored unless master enable set
// - master enable self-clears four cycles later
// - write strobe writes data byte at address
// - write strobe clears after write time
// - write strobe stalls processor four cycles
// - read strobe clears, data register holds byte
// - read stalls processor two cycles
module nv_access #(
    parameter int ADDR_W = 9,
    parameter logic [15:0] WRITE_CYCLES = `NV_WRITE_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic cpu_stall,
    output logic ready_irq,
    output logic irq
);
    localparam int DEPTH = 1 << ADDR_W;
    logic [7:0] mem [DEPTH];
    logic rie, mwe, ws, rs;
    logic [2:0] mwe_cnt;
    logic [2:0] stall_cnt;
    logic [15:0] wcnt;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata, rdata;
    logic gie;
    logic [2:0] stat, mask;
    logic [2:0] ev;
    nv_access_pkg::nv_state_t state;
    logic wr, ctrl_wr, ws_req, rs_req, ws_go, known;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    assign wr = psel && penable && pwrite;
    assign ctrl_wr = wr && hit(paddr, `NV_CTRL_OFS);
    assign ws_req = ctrl_wr && pwdata[`NV_BIT_WS] && !ws;
    assign rs_req = ctrl_wr && pwdata[`NV_BIT_RS] && !ws && !rs;
    assign ws_go = ws_req && mwe;
    assign pready = 1'b1;
    assign known = hit(paddr, `NV_CTRL_OFS) || hit(paddr, `NV_ADDR_OFS)
        || hit(paddr, `NV_WDATA_OFS) || hit(paddr, `NV_RDATA_OFS)
        || hit(paddr, `NV_STAT_OFS) || hit(paddr, `NV_MASK_OFS)
        || hit(paddr, `NV_GIE_OFS);
    assign pslverr = psel && penable && !known;
    assign ready_irq = gie && rie && !ws;
    assign irq = |(stat & mask);
    assign cpu_stall = stall_cnt != 3'h0;

    always_ff @(posedge clk) begin
        if (srst) begin
            rie <= 1'b0;
        end else if (ctrl_wr) begin
            rie <= pwdata[`NV_BIT_RIE];
        end
    end

    // master enable lives only a short window, so a stray strobe can't write
    always_ff @(posedge clk) begin
        if (srst) begin
            mwe <= 1'b0;
            mwe_cnt <= 3'h0;
        end else if (ctrl_wr && pwdata[`NV_BIT_MWE]) begin
            mwe <= 1'b1;
            mwe_cnt <= `NV_MWE_CYCLES;
        end else if (mwe_cnt > 3'h1) begin
            mwe_cnt <= mwe_cnt - 3'h1;
        end else begin
            mwe <= 1'b0;
            mwe_cnt <= 3'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            addr <= '0;
            wdata <= 8'h00;
            gie <= 1'b0;
            mask <= 3'h0;
        end else if (wr && !ws) begin
            // address and data frozen while a write is in flight
            if (hit(paddr, `NV_ADDR_OFS)) begin
                addr <= pwdata[ADDR_W-1:0];
            end
            if (hit(paddr, `NV_WDATA_OFS)) begin
                wdata <= pwdata[7:0];
            end
            if (hit(paddr, `NV_GIE_OFS)) begin
                gie <= pwdata[0];
            end
            if (hit(paddr, `NV_MASK_OFS)) begin
                mask <= pwdata[2:0];
            end
        end else if (wr) begin
            if (hit(paddr, `NV_GIE_OFS)) begin
                gie <= pwdata[0];
            end
            if (hit(paddr, `NV_MASK_OFS)) begin
                mask <= pwdata[2:0];
            end
        end
    end

    // a busy write blocks both strobes, so only one access runs at a time
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= nv_access_pkg::st_idle;
            ws <= 1'b0;
            rs <= 1'b0;
            wcnt <= 16'h0000;
        end else begin
            unique case (state)
                nv_access_pkg::st_idle: begin
                    if (ws_go) begin
                        ws <= 1'b1;
                        wcnt <= WRITE_CYCLES;
                        state <= nv_access_pkg::st_write;
                    end else if (rs_req) begin
                        rs <= 1'b1;
                        state <= nv_access_pkg::st_read;
                    end
                end
                nv_access_pkg::st_write: begin
                    if (wcnt > 16'h0001) begin
                        wcnt <= wcnt - 16'h0001;
                    end else begin
                        ws <= 1'b0;
                        state <= nv_access_pkg::st_idle;
                    end
                end
                nv_access_pkg::st_read: begin
                    rs <= 1'b0;
                    state <= nv_access_pkg::st_idle;
                end
                default: begin
                    state <= nv_access_pkg::st_idle;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (state == nv_access_pkg::st_write && wcnt == 16'h0001) begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= 8'h00;
        end else if (state == nv_access_pkg::st_read) begin
            rdata <= mem[addr];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            stall_cnt <= 3'h0;
        end else if (ws_go) begin
            stall_cnt <= `NV_WSTALL_CYCLES;
        end else if (rs_req && state == nv_access_pkg::st_idle) begin
            stall_cnt <= `NV_RSTALL_CYCLES;
        end else if (stall_cnt != 3'h0) begin
            stall_cnt <= stall_cnt - 3'h1;
        end
    end

    always_comb begin
        ev = 3'h0;
        ev[`NV_EV_WDONE] = state == nv_access_pkg::st_write
            && wcnt == 16'h0001;
        ev[`NV_EV_RDONE] = state == nv_access_pkg::st_read;
        ev[`NV_EV_WIGN] = ws_req && !mwe;
    end

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            stat <= 3'h0;
        end else if (wr && hit(paddr, `NV_STAT_OFS)) begin
            stat <= (stat & ~pwdata[2:0]) | ev;
        end else begin
            stat <= stat | ev;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                `NV_CTRL_OFS: prdata <= {28'h0, rie, mwe, ws, rs};
                `NV_ADDR_OFS: prdata <= 32'(addr);
                `NV_WDATA_OFS: prdata <= {24'h0, wdata};
                `NV_RDATA_OFS: prdata <= {24'h0, rdata};
                `NV_STAT_OFS: prdata <= {29'h0, stat};
                `NV_MASK_OFS: prdata <= {29'h0, mask};
                `NV_GIE_OFS: prdata <= {31'h0, gie};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // a reset can cut a write short, so falling edges skip the reset edge
    a_mwe_timeout: assert property (@(posedge clk) disable iff (srst)
        $rose(mwe) |-> mwe [*4] ##1 !mwe)
        else $error("master enable did not clear after four cycles");

    a_mwe_set: assert property (@(posedge clk) disable iff (srst)
        ctrl_wr && pwdata[`NV_BIT_MWE] |=> mwe)
        else $error("master enable not set by software");

    a_ws_needs_mwe: assert property (@(posedge clk) disable iff (srst)
        $rose(ws) |-> $past(mwe))
        else $error("write started without master enable");

    a_ign_flag: assert property (@(posedge clk) disable iff (srst)
        ctrl_wr && pwdata[`NV_BIT_WS] && !ws && !mwe
        |=> !ws && stat[`NV_EV_WIGN])
        else $error("unarmed write strobe not ignored");

    a_wstall_len: assert property (@(posedge clk) disable iff (srst)
        $rose(ws) |-> cpu_stall [*4] ##1 !cpu_stall)
        else $error("write stall not four cycles");

    a_stall_src: assert property (@(posedge clk) disable iff (srst)
        $rose(cpu_stall) |-> $rose(ws) || $rose(rs))
        else $error("stall without a strobe");

    a_ws_holds: assert property (@(posedge clk) disable iff (srst)
        ws && wcnt > 16'h0001 |=> ws)
        else $error("write strobe cleared before write time");

    a_ws_done_cnt: assert property (@(posedge clk) disable iff (srst)
        $fell(ws) && !$past(srst) |-> $past(wcnt) == 16'h0001)
        else $error("write strobe cleared at wrong count");

    a_stat_sticky: assert property (@(posedge clk) disable iff (srst)
        $past(stat[`NV_EV_WDONE]) && !$past(srst)
        && !$past(wr && paddr == `NV_STAT_OFS && pwdata[`NV_EV_WDONE])
        |-> stat[`NV_EV_WDONE])
        else $error("write done flag lost");

    a_mem_write: assert property (@(posedge clk) disable iff (srst)
        $fell(ws) && !$past(srst) |-> mem[addr] == wdata)
        else $error("data byte not stored");

    a_addr_frozen: assert property (@(posedge clk) disable iff (srst)
        ws |=> $stable(addr))
        else $error("address changed during a write");

    a_wdata_frozen: assert property (@(posedge clk) disable iff (srst)
        ws |=> $stable(wdata))
        else $error("write data changed during a write");

    a_rs_idle: assert property (@(posedge clk) disable iff (srst)
        $rose(rs) |-> !ws)
        else $error("read started during a write");

    a_rs_clear: assert property (@(posedge clk) disable iff (srst)
        rs |=> !rs)
        else $error("read strobe held too long");

    a_rstall_len: assert property (@(posedge clk) disable iff (srst)
        $rose(rs) |-> cpu_stall [*2] ##1 !cpu_stall)
        else $error("read stall not two cycles");

    a_rie_gate: assert property (@(posedge clk) disable iff (srst)
        (ctrl_wr && !pwdata[`NV_BIT_RIE])
        || (wr && paddr == `NV_GIE_OFS && !pwdata[0]) |=> !ready_irq)
        else $error("ready interrupt not gated off");

    a_irq_off_busy: assert property (@(posedge clk) disable iff (srst)
        ws |-> !ready_irq)
        else $error("ready interrupt during write");

    a_ctrl_upper: assert property (@(posedge clk) disable iff (srst)
        $past(psel && !penable && !pwrite && paddr == `NV_CTRL_OFS)
        |-> prdata[31:4] == 28'h0)
        else $error("reserved bits not zero");
endmodule
`default_nettype wire

//--- inc/nv_access_defs.svh
// Purpose: offsets, field positions, reset values, timing counts
// Assumes: apb byte addresses, one 32-bit word per register
// Notes: definitions only
`ifndef NV_ACCESS_DEFS_SVH
`define NV_ACCESS_DEFS_SVH
`define NV_CTRL_OFS 8'h1C
`define NV_ADDR_OFS 8'h20
`define NV_WDATA_OFS 8'h24
`define NV_RDATA_OFS 8'h28
`define NV_STAT_OFS 8'h2C
`define NV_MASK_OFS 8'h30
`define NV_GIE_OFS 8'h34
`define NV_CTRL_RESET 8'h00
`define NV_BIT_RIE 3
`define NV_BIT_MWE 2
`define NV_BIT_WS 1
`define NV_BIT_RS 0
`define NV_MWE_CYCLES 3'h4
`define NV_WSTALL_CYCLES 3'h4
`define NV_RSTALL_CYCLES 3'h2
`define NV_WRITE_CYCLES 16'h0100
`define NV_EV_WDONE 0
`define NV_EV_RDONE 1
`define NV_EV_WIGN 2
`endif

//--- inc/nv_access_pkg.sv
// Purpose: types for the nonvolatile access block
// Assumes: nothing
// Notes: constants live in the defs header
`default_nettype none
package nv_access_pkg;
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_write = 2'b01,
        st_read = 2'b10
    } nv_state_t;
endpackage
`default_nettype wire

//--- test/nv_access_tb.sv
// Purpose: apb-driven checks of the nonvolatile access control block
// Assumes: zero-wait apb slave; write time cut to 8 cycles
// Notes: stalls counted as high cycles of cpu_stall, not timed by edge
`include "nv_access_defs.svh"
`default_nettype none
module nv_access_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cpu_stall;
    logic ready_irq;
    logic irq;
    logic [31:0] rd;
    logic err;
    int fail_count = 0;
    int total_checks = 0;
    int stalls = 0;
    int s0;
    always #2.5 clk = ~clk;
    // running count lets a test measure stall length without edge races
    always @(posedge clk) begin
        if (cpu_stall === 1'b1) stalls <= stalls + 1;
    end
    nv_access #(.WRITE_CYCLES(16'h0008)) uut (.clk(clk), .srst(srst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cpu_stall(cpu_stall), .ready_irq(ready_irq),
        .irq(irq));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one apb transfer; request held until pready is seen high
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #20000;
        fail_count++;
        end_of_test();
    end
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        xfer(1'b0, `NV_CTRL_OFS, 32'h0); check(rd, 32'h0);
        xfer(1'b1, `NV_CTRL_OFS, 32'hF0);
        xfer(1'b0, `NV_CTRL_OFS, 32'h0); check(rd, 32'h0);
        $display("test reserved bits done");
        // strobe with no master enable must leave the store alone
        xfer(1'b1, `NV_CTRL_OFS, 32'h02);
        xfer(1'b0, `NV_CTRL_OFS, 32'h0); check(rd, 32'h0);
        xfer(1'b0, `NV_STAT_OFS, 32'h0); check(rd, 32'h04);
        @(negedge clk); check(irq, 1'b0);
        xfer(1'b1, `NV_MASK_OFS, 32'h04);
        @(negedge clk); check(irq, 1'b1);
        xfer(1'b1, `NV_STAT_OFS, 32'h04);
        @(negedge clk); check(irq, 1'b0);
        xfer(1'b1, `NV_MASK_OFS, 32'h01);
        $display("test ignored strobe done");
        xfer(1'b1, `NV_CTRL_OFS, 32'h04);
        xfer(1'b0, `NV_CTRL_OFS, 32'h0); check(rd, 32'h04);
        repeat (4) @(posedge clk);
        xfer(1'b0, `NV_CTRL_OFS, 32'h0); check(rd, 32'h0);
        xfer(1'b1, `NV_CTRL_OFS, 32'h02);
        xfer(1'b0, `NV_STAT_OFS, 32'h0); check(rd, 32'h04);
        xfer(1'b1, `NV_STAT_OFS, 32'h04);
        $display("test enable timeout done");
        xfer(1'b1, `NV_GIE_OFS, 32'h01);
        xfer(1'b1, `NV_CTRL_OFS, 32'h08);
        @(negedge clk); check(ready_irq, 1'b1);
        xfer(1'b1, `NV_GIE_OFS, 32'h0);
        xfer(1'b1, `NV_ADDR_OFS, 32'h1A5);
        xfer(1'b1, `NV_WDATA_OFS, 32'h3C);
        xfer(1'b1, `NV_CTRL_OFS, 32'h0C);
        s0 = stalls;
        xfer(1'b1, `NV_CTRL_OFS, 32'h0A);
        xfer(1'b1, `NV_GIE_OFS, 32'h01);
        @(negedge clk); check(ready_irq, 1'b0);
        xfer(1'b0, `NV_CTRL_OFS, 32'h0); check(rd & 32'hFB, 32'h0A);
        repeat (3) @(posedge clk);
        check(stalls - s0, 32'h4);
        repeat (20) begin
            xfer(1'b0, `NV_CTRL_OFS, 32'h0);
            if (rd[1] === 1'b0) break;
        end
        check(rd[1], 1'b0);
        @(negedge clk); check(ready_irq, 1'b1);
        check(irq, 1'b1);
        xfer(1'b1, `NV_STAT_OFS, 32'h01);
        @(negedge clk); check(irq, 1'b0);
        $display("test write done");
        s0 = stalls;
        xfer(1'b1, `NV_CTRL_OFS, 32'h09);
        repeat (4) @(posedge clk);
        check(stalls - s0, 32'h2);
        xfer(1'b0, `NV_RDATA_OFS, 32'h0); check(rd & 32'hFF, 32'h3C);
        check(err, 1'b0);
        check(pready, 1'b1);
        xfer(1'b0, `NV_CTRL_OFS, 32'h0); check(rd, 32'h08);
        $display("test read done");
        xfer(1'b1, `NV_GIE_OFS, 32'h0);
        @(negedge clk); check(ready_irq, 1'b0);
        xfer(1'b1, `NV_GIE_OFS, 32'h01);
        xfer(1'b1, `NV_CTRL_OFS, 32'h0);
        @(negedge clk); check(ready_irq, 1'b0);
        xfer(1'b0, 8'h3C, 32'h0); check(err, 1'b1);
        $display("test gating done");
        end_of_test();
    end
endmodule
`default_nettype wire
